//--- src/rfhs_map.svh
// rx frame header status block: offsets, bit positions, constants
// assumes inclusion by the principal design file only
`ifndef RFHS_MAP_SVH
`define RFHS_MAP_SVH

`define RFHS_OFS_STATUS 8'h7C
`define RFHS_OFS_COUNT 8'h80
`define RFHS_OFS_POP 8'h84
`define RFHS_OFS_IRQ_STAT 8'h88
`define RFHS_OFS_IRQ_MASK 8'h8C

`define RFHS_BIT_VALID 15
`define RFHS_BIT_ICMP 13
`define RFHS_BIT_IP 12
`define RFHS_BIT_TCP 11
`define RFHS_BIT_UDP 10
`define RFHS_BIT_BCAST 7
`define RFHS_BIT_MCAST 6
`define RFHS_BIT_UCAST 5
`define RFHS_BIT_SYM 4
`define RFHS_BIT_ETYPE 3
`define RFHS_BIT_LONG 2
`define RFHS_BIT_RUNT 1
`define RFHS_BIT_FCS 0
`define RFHS_BIT_RSV14 14
`define RFHS_BIT_RSV9 9
`define RFHS_BIT_RSV8 8

`define RFHS_BIT_GROUP 40
`define RFHS_HTRANS_ACT 1
`define RFHS_POP_BIT 0

`define RFHS_ETYPE_MIN 16'h05DC
`define RFHS_LONG_MAX 16'h07D0

`define RFHS_IRQ_DONE 0
`define RFHS_IRQ_OVF 1

`endif

//--- src/rfhs_pkg.sv
// rx frame header status block: shared types
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package rfhs_pkg;
  typedef enum logic [1:0] {RFHS_IDLE, RFHS_ADDR, RFHS_DATA} rfhs_bus_t;
endpackage : rfhs_pkg
`default_nettype wire

//--- src/rfhs_status.sv
// rx frame header status queue with AHB-Lite register slave
// assumes the receive engine reports one end pulse per frame, same clock
// Functional notes
// RL1 - status word readable once per counted pending frame, one per frame
// RL2 - bit 15 set when head frame is complete and valid
// RL3 - other bits meaningful for head frame whenever valid bit set
// RL4 - valid reads zero when nothing pending or head still receiving
// RL5 - bit 13 flags bad ICMP checksum
// RL6 - bit 12 flags bad IP header checksum
// RL7 - bit 11 flags bad TCP checksum
// RL8 - bit 10 flags bad UDP checksum
// RL9 - bit 7 flags broadcast destination
// RL10 - bit 6 flags any multicast, broadcast included
// RL11 - bit 5 flags unicast destination
// RL12 - bit 4 flags media symbol error during frame
// RL13 - bit 3 set when length/type field above 1500, else clear
// RL14 - host ignores frame-type bit for runt frames
// RL15 - bit 2 flags frame over 2000 bytes, no truncation
// RL16 - bit 1 flags runt frame
// RL17 - bit 0 flags FCS error
// RL18 - status stable until host advances; bits 14, 9, 8 read zero
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "rfhs_map.svh"

module rfhs_status #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  // receive engine side
  input wire logic frame_end,
  input wire logic [15:0] frame_len,
  input wire logic [15:0] len_type,
  input wire logic [47:0] dest_addr,
  input wire logic icmp_checksum_bad,
  input wire logic ip_header_checksum_bad,
  input wire logic tcp_checksum_bad,
  input wire logic udp_checksum_bad,
  input wire logic media_symbol_error,
  input wire logic runt_frame,
  input wire logic fcs_error,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [AW:0] count;
    rfhs_pkg::rfhs_bus_t bus;
    logic wr_act;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
    logic rdy;
    logic resp;
  } rfhs_state_t;

  rfhs_state_t cur_ff;
  rfhs_state_t nxt_st;

  // ==========================================================
  // status word assembly
  logic [15:0] new_word;
  logic bcast;
  logic mcast;
  logic [15:0] head_word;
  logic take_addr;
  logic pop_wr;
  logic do_push;
  logic do_pop;
  logic data_ph;
  logic wr_hit;

  always_comb begin
    bcast = &dest_addr;
    mcast = dest_addr[`RFHS_BIT_GROUP];
    new_word = 16'h0000;
    new_word[`RFHS_BIT_VALID] = 1'b1; // RL2
    new_word[`RFHS_BIT_ICMP] = icmp_checksum_bad; // RL5
    new_word[`RFHS_BIT_IP] = ip_header_checksum_bad; // RL6
    new_word[`RFHS_BIT_TCP] = tcp_checksum_bad; // RL7
    new_word[`RFHS_BIT_UDP] = udp_checksum_bad; // RL8
    new_word[`RFHS_BIT_BCAST] = bcast; // RL9
    new_word[`RFHS_BIT_MCAST] = mcast; // RL10
    new_word[`RFHS_BIT_UCAST] = ~mcast; // RL11
    new_word[`RFHS_BIT_SYM] = media_symbol_error; // RL12
    new_word[`RFHS_BIT_ETYPE] = len_type > `RFHS_ETYPE_MIN; // RL13
    new_word[`RFHS_BIT_LONG] = frame_len > `RFHS_LONG_MAX; // RL15
    new_word[`RFHS_BIT_RUNT] = runt_frame; // RL16
    new_word[`RFHS_BIT_FCS] = fcs_error; // RL17
  end

  // valid only for a fully stored frame; empty queue reads zero
  assign head_word = (cur_ff.count != '0) ?
    cur_ff.mem[cur_ff.rd_ptr] : 16'h0000; // RL4 RL18

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = cur_ff;
    data_ph = (cur_ff.bus == rfhs_pkg::RFHS_DATA);
    wr_hit = data_ph && cur_ff.wr_act;
    take_addr = hsel && hready && htrans[`RFHS_HTRANS_ACT];
    pop_wr = wr_hit && (cur_ff.addr == `RFHS_OFS_POP) &&
      hwdata[`RFHS_POP_BIT];
    do_pop = pop_wr && (cur_ff.count != '0); // RL1
    do_push = frame_end && (cur_ff.count != (AW + 1)'(DEPTH));
    if (do_push) begin
      nxt_st.mem[cur_ff.wr_ptr] = new_word; // RL3
      nxt_st.wr_ptr = cur_ff.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      nxt_st.rd_ptr = cur_ff.rd_ptr + 1'b1; // RL18
    end
    nxt_st.count = cur_ff.count + (AW + 1)'(do_push) -
      (AW + 1)'(do_pop); // RL1
    // irq status: write one clears, a new event wins
    if (wr_hit && cur_ff.addr == `RFHS_OFS_IRQ_STAT) begin
      nxt_st.istat = cur_ff.istat & ~hwdata[`RFHS_IRQ_OVF:`RFHS_IRQ_DONE];
    end
    if (wr_hit && cur_ff.addr == `RFHS_OFS_IRQ_MASK) begin
      nxt_st.imask = hwdata[`RFHS_IRQ_OVF:`RFHS_IRQ_DONE];
    end
    if (do_push) begin
      nxt_st.istat[`RFHS_IRQ_DONE] = 1'b1;
    end
    if (frame_end && !do_push) begin
      nxt_st.istat[`RFHS_IRQ_OVF] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.istat & nxt_st.imask);
    // bus: single-cycle data phase, zero wait
    nxt_st.wr_act = 1'b0;
    nxt_st.bus = rfhs_pkg::RFHS_IDLE;
    nxt_st.rdy = 1'b1;
    nxt_st.resp = 1'b0;
    if (take_addr) begin
      nxt_st.bus = rfhs_pkg::RFHS_DATA;
      nxt_st.addr = haddr;
      nxt_st.wr_act = hwrite;
      unique case (haddr)
        `RFHS_OFS_STATUS: nxt_st.rdata = 32'(head_word);
        `RFHS_OFS_COUNT: nxt_st.rdata = 32'(nxt_st.count);
        `RFHS_OFS_IRQ_STAT: nxt_st.rdata = 32'(nxt_st.istat);
        `RFHS_OFS_IRQ_MASK: nxt_st.rdata = 32'(nxt_st.imask);
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
      // slave stays ready through reset
      cur_ff.rdy <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign hrdata = cur_ff.rdata;
  assign hreadyout = cur_ff.rdy;
  assign hresp = cur_ff.resp;
  assign irq = cur_ff.irq;

  // ==========================================================
  // checks
  // queue occupancy and head word
  reserved_zero_a: assert property ( // RL18
    @(posedge sys_clk) disable iff (!rst_b)
    (head_word[`RFHS_BIT_RSV14] == 1'b0) &&
    (head_word[`RFHS_BIT_RSV9:`RFHS_BIT_RSV8] == 2'b00))
    else $error("reserved status bits not zero");
  empty_invalid_a: assert property ( // RL4
    @(posedge sys_clk) disable iff (!rst_b)
    (cur_ff.count == '0) |-> !head_word[`RFHS_BIT_VALID])
    else $error("valid set with empty queue");
  head_valid_a: assert property ( // RL2
    @(posedge sys_clk) disable iff (!rst_b)
    (cur_ff.count != '0) |-> head_word[`RFHS_BIT_VALID])
    else $error("pending frame without valid");
  head_stable_a: assert property ( // RL18
    @(posedge sys_clk) disable iff (!rst_b)
    (cur_ff.count != '0 && !do_pop) |=> $stable(head_word))
    else $error("head status changed without advance");
  bcast_mcast_a: assert property ( // RL10
    @(posedge sys_clk) disable iff (!rst_b)
    head_word[`RFHS_BIT_BCAST] |-> head_word[`RFHS_BIT_MCAST])
    else $error("broadcast without multicast");
  ucast_excl_a: assert property ( // RL11
    @(posedge sys_clk) disable iff (!rst_b)
    head_word[`RFHS_BIT_VALID] |->
    (head_word[`RFHS_BIT_UCAST] != head_word[`RFHS_BIT_MCAST]))
    else $error("unicast and multicast disagree");
  count_max_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    cur_ff.count <= (AW + 1)'(DEPTH))
    else $error("frame count above depth");
  count_up_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (do_push && !do_pop) |=>
    cur_ff.count == $past(cur_ff.count) + 1'b1)
    else $error("frame count not incremented");
  count_down_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (do_pop && !do_push) |=>
    cur_ff.count == $past(cur_ff.count) - 1'b1)
    else $error("frame count not decremented");
  count_hold_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (do_push == do_pop) |=> $stable(cur_ff.count))
    else $error("frame count moved without push or pop");
  pop_advance_a: assert property ( // RL18
    @(posedge sys_clk) disable iff (!rst_b)
    do_pop |=>
    cur_ff.rd_ptr == $past(cur_ff.rd_ptr) + 1'b1)
    else $error("head did not advance on pop");
  pop_empty_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (pop_wr && cur_ff.count == '0) |=> $stable(cur_ff.rd_ptr))
    else $error("pop of empty queue moved head");
  drop_full_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (frame_end && cur_ff.count == (AW + 1)'(DEPTH)) |=>
    $stable(cur_ff.wr_ptr))
    else $error("frame stored into full queue");

  // stored status word against the flags of its frame
  valid_store_a: assert property ( // RL2
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=>
    cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_VALID])
    else $error("stored frame not marked valid");
  icmp_store_a: assert property ( // RL5
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_ICMP] ==
    $past(icmp_checksum_bad))
    else $error("icmp checksum bit wrong");
  ip_store_a: assert property ( // RL6
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_IP] ==
    $past(ip_header_checksum_bad))
    else $error("ip header checksum bit wrong");
  tcp_store_a: assert property ( // RL7
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_TCP] ==
    $past(tcp_checksum_bad))
    else $error("tcp checksum bit wrong");
  udp_store_a: assert property ( // RL8
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_UDP] ==
    $past(udp_checksum_bad))
    else $error("udp checksum bit wrong");
  bcast_store_a: assert property ( // RL9
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_BCAST] ==
    (&$past(dest_addr)))
    else $error("broadcast bit wrong");
  mcast_store_a: assert property ( // RL10
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_MCAST] ==
    $past(mcast))
    else $error("multicast bit wrong");
  ucast_store_a: assert property ( // RL11
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_UCAST] ==
    !$past(mcast))
    else $error("unicast bit wrong");
  sym_store_a: assert property ( // RL12
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_SYM] ==
    $past(media_symbol_error))
    else $error("symbol error bit wrong");
  runt_store_a: assert property ( // RL16
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.mem[$past(cur_ff.wr_ptr)][`RFHS_BIT_RUNT] ==
    $past(runt_frame))
    else $error("runt bit wrong");
  etype_set_a: assert property ( // RL13
    @(posedge sys_clk) disable iff (!rst_b)
    (do_push && cur_ff.count == '0) |=>
    head_word[`RFHS_BIT_ETYPE] == ($past(len_type) > `RFHS_ETYPE_MIN))
    else $error("frame type bit wrong");
  long_set_a: assert property ( // RL15
    @(posedge sys_clk) disable iff (!rst_b)
    (do_push && cur_ff.count == '0) |=>
    head_word[`RFHS_BIT_LONG] == ($past(frame_len) > `RFHS_LONG_MAX))
    else $error("too long bit wrong");
  fcs_set_a: assert property ( // RL17
    @(posedge sys_clk) disable iff (!rst_b)
    (do_push && cur_ff.count == '0) |=>
    head_word[`RFHS_BIT_FCS] == $past(fcs_error))
    else $error("fcs bit wrong");

  // interrupt flags and register reads
  done_flag_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    do_push |=> cur_ff.istat[`RFHS_IRQ_DONE])
    else $error("stored frame event not flagged");
  ovf_flag_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (frame_end && !do_push) |=> cur_ff.istat[`RFHS_IRQ_OVF])
    else $error("dropped frame not flagged");
  irq_level_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    irq == |(cur_ff.istat & cur_ff.imask))
    else $error("interrupt level disagrees with status");
  mask_write_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_hit && cur_ff.addr == `RFHS_OFS_IRQ_MASK) |=>
    cur_ff.imask == 2'($past(hwdata)))
    else $error("interrupt mask write lost");
  read_status_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (take_addr && !hwrite && haddr == `RFHS_OFS_STATUS) |=>
    hrdata == 32'($past(head_word)))
    else $error("status read data wrong");
  read_count_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (take_addr && !hwrite && haddr == `RFHS_OFS_COUNT) |=>
    hrdata == 32'(cur_ff.count))
    else $error("pending count read data wrong");
  read_irq_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    (take_addr && !hwrite && haddr == `RFHS_OFS_IRQ_STAT) |=>
    hrdata == 32'(cur_ff.istat))
    else $error("interrupt status read data wrong");
  hrdata_hold_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (!rst_b)
    !take_addr |=> $stable(hrdata))
    else $error("read data moved without request");

endmodule : rfhs_status

`default_nettype wire

//--- verif/rfhs_host_model.sv
// host model: AHB-Lite master, one single word transfer per go pulse
// assumes the slave's hreadyout comes back as hready
`timescale 1ns/100ps
`default_nettype none
module rfhs_host_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic [31:0] wd,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata,
  output logic [31:0] rd,
  output logic done
);
  logic [1:0] ph_ff;
  logic [31:0] wd_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_ff <= 2'h0;
      htrans <= 2'h0;
      haddr <= 8'h00;
      hwrite <= 1'b0;
      hwdata <= 32'h0;
      rd <= 32'h0;
      done <= 1'b0;
      wd_ff <= 32'h0;
    end else begin
      done <= 1'b0;
      if (ph_ff == 2'h0 && go) begin
        ph_ff <= 2'h1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        wd_ff <= wd;
      end else if (ph_ff == 2'h1 && hready) begin
        ph_ff <= 2'h2;
        htrans <= 2'h0;
        hwdata <= wd_ff;
      end else if (ph_ff == 2'h2 && hready) begin
        // one answer per request, write data released afterwards
        ph_ff <= 2'h0;
        rd <= hrdata;
        done <= 1'b1;
        hwdata <= ~wd_ff;
      end
    end
  end
endmodule : rfhs_host_model
`default_nettype wire

//--- verif/testbench.sv
// bench: frames into the status queue, host reads and pops them
// assumes rfhs_status and rfhs_host_model compiled before it
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b1;
  logic frame_end = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [6:0] fl = 7'h00;
  logic [15:0] flen = 16'h0000;
  logic [15:0] lt = 16'h0000;
  logic [47:0] da = 48'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite, hready, hresp, irq, done;
  logic [31:0] wd = 32'h0;
  logic [31:0] hwdata, hrdata, rd, ex, mk;
  logic [31:0] exp_q[$], msk_q[$], fq[$], fm[$];
  int err_count = 0;
  int cmp_count = 0;
  always #50 sys_clk = ~sys_clk;
  rfhs_status u_rfhs_status (.sys_clk, .rst_b, .frame_end,
    .frame_len(flen), .len_type(lt), .dest_addr(da),
    .icmp_checksum_bad(fl[6]), .ip_header_checksum_bad(fl[5]),
    .tcp_checksum_bad(fl[4]), .udp_checksum_bad(fl[3]),
    .media_symbol_error(fl[2]), .runt_frame(fl[1]), .fcs_error(fl[0]),
    .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .irq);
  rfhs_host_model u_rfhs_host_model (.sys_clk, .rst_b, .go, .addr, .wr,
    .wd, .hready, .hrdata, .haddr, .htrans, .hwrite, .hwdata, .rd, .done);
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr <= w;
    wd <= d;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(negedge sys_clk iff done);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 1'b0, 32'h0);
  endtask : rdc
  task automatic frame(input int i);
    logic [47:0] r;
    logic [6:0] f;
    logic [15:0] l, n;
    r = 48'({$urandom, $urandom});
    r[40] = (i % 3 != 2);
    if (i % 3 == 0) r = '1;
    f = 7'($urandom);
    l = 16'h05DB + 16'(i);
    n = 16'h07CF + 16'(i);
    @(posedge sys_clk);
    frame_end <= 1'b1;
    fl <= f;
    lt <= l;
    flen <= n;
    da <= r;
    if (i < 8) begin
      fq.push_back({16'h0, 2'b10, f[6:3], 2'b00, &r, r[40], !r[40], f[2],
        l > 16'h05DC, n > 16'h07D0, f[1:0]});
      fm.push_back(f[1] ? 32'hFFFFFFF7 : 32'hFFFFFFFF);
    end
  endtask : frame
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  always @(posedge sys_clk) begin
    if (done === 1'b1 && !wr) begin
      ex = exp_q.pop_front();
      mk = msk_q.pop_front();
      chk(rd & mk, ex & mk);
    end
  end
  initial begin
    #300000;
    err_count++;
    conclude();
  end
  initial begin
    int i;
    void'($urandom(24));
    rst_b = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(8'h7C, 32'h0, '1);
    for (i = 0; i < 9; i++) frame(i);
    @(posedge sys_clk);
    frame_end <= 1'b0;
    rdc(8'h80, 32'h8, '1);
    chk({31'h0, irq}, 32'h0);
    bus(8'h8C, 1'b1, 32'h3);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    rdc(8'h88, 32'h3, '1);
    bus(8'h88, 1'b1, 32'h3);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(8'hF0, 32'h0, '1);
    for (i = 0; i < 8; i++) begin
      rdc(8'h7C, fq[i], fm[i]);
      rdc(8'h7C, fq[i], fm[i]);
      bus(8'h84, 1'b1, 32'h1);
    end
    rdc(8'h7C, 32'h0, '1);
    rdc(8'h80, 32'h0, '1);
    chk({31'h0, hresp}, 32'h0);
    wait (exp_q.size() == 0);
    @(negedge sys_clk);
    conclude();
  end
endmodule : testbench
`default_nettype wire
